//--- rtl/pdws_cfg.svh
// Timing and layout constants for the wiper stepper
`ifndef PDWS_CFG_SVH
`define PDWS_CFG_SVH

`define PDWS_CLK_KHZ         50000
`define PDWS_POS_W           6
`define PDWS_POS_MAX         6'h3F
`define PDWS_POS_RST         6'h00
`define PDWS_DIG_MIN_NS      1000
`define PDWS_CON_MIN_US      1000
`define PDWS_GAP_US          1000
`define PDWS_HOLD_MS         1000
`define PDWS_REPEAT_MS       100
`define PDWS_IDLE_MS         1000
`define PDWS_STORE_MS        2000
`define PDWS_STORE_MIN_DELTA 6'h08

// Least times round up to whole cycles
`define PDWS_CYC_NS(t) ((((t) * `PDWS_CLK_KHZ) + 999999) / 1000000)
`define PDWS_CYC_US(t) ((((t) * `PDWS_CLK_KHZ) + 999) / 1000)
`define PDWS_CYC_MS(t) ((t) * `PDWS_CLK_KHZ)

`endif

//--- rtl/pdws_pkg.sv
// Types shared by the wiper stepper modules
`default_nettype none
package pdws_pkg;
  typedef logic [5:0] pdws_pos_t;

  typedef enum logic [1:0] {
    pdws_q_idle = 2'b00,
    pdws_q_low  = 2'b01,
    pdws_q_gap  = 2'b10
  } pdws_qstate_e;

  typedef struct packed {
    logic step;
    logic idle;
  } pdws_evt_s;

  typedef struct packed {
    logic      strobe;
    pdws_pos_t data;
  } pdws_nv_s;
endpackage
`default_nettype wire

//--- rtl/pdws_pulse_qual.sv
// Input qualifier: sync, pulse width timing, repeat and idle events
`default_nettype none
module pdws_pulse_qual #(
  parameter int MIN_CYC    = 50000,
  parameter int GAP_CYC    = 50000,
  parameter int HOLD_CYC   = 50000000,
  parameter int REPEAT_CYC = 5000000,
  parameter int IDLE_CYC   = 50000000
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          pin_n,
  output var  pdws_pkg::pdws_evt_s evt
);
  import pdws_pkg::*;

  localparam int TOP = (HOLD_CYC > IDLE_CYC) ? HOLD_CYC : IDLE_CYC;
  localparam int CW  = $clog2(TOP + 1);

  if (MIN_CYC < 1 || GAP_CYC < 1 || REPEAT_CYC < 1 || IDLE_CYC < 1 ||
      HOLD_CYC <= MIN_CYC) begin : g_bad_timing
    $error("pdws_pulse_qual: timing counts out of range");
  end

  logic          sync1_reg;
  logic          sync2_reg;
  pdws_qstate_e  state_reg;
  logic [CW-1:0] low_cnt_reg;
  logic [CW-1:0] gap_cnt_reg;
  logic [CW-1:0] rep_cnt_reg;
  logic [CW-1:0] idle_cnt_reg;
  logic          low;

  // ------------------------------------------------------------
  // Synchroniser
  // ------------------------------------------------------------
  // Reset to high: an open input reads inactive
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= 1'b1; // RQ8
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= pin_n; // RQ19
      sync2_reg <= sync1_reg;
    end
  end

  assign low = !sync2_reg; // RQ10

  // ------------------------------------------------------------
  // Pulse state
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= pdws_q_idle;
    end else begin
      case (state_reg)
        pdws_q_idle: if (low) state_reg <= pdws_q_low; // RQ10
        pdws_q_low:  if (!low) state_reg <= pdws_q_gap;
        pdws_q_gap: begin
          // Short high gap merges into one continuous pulse
          if (low) begin
            state_reg <= pdws_q_low; // RQ13
          end else if (gap_cnt_reg == CW'(GAP_CYC - 1)) begin
            state_reg <= pdws_q_idle;
          end
        end
        default: state_reg <= pdws_q_idle;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst || state_reg != pdws_q_gap) begin
      gap_cnt_reg <= '0;
    end else begin
      gap_cnt_reg <= gap_cnt_reg + CW'(1);
    end
  end

  // Keeps counting through merged gaps; saturates at the hold time
  always_ff @(posedge clock) begin
    if (rst || state_reg == pdws_q_idle) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != CW'(HOLD_CYC)) begin
      low_cnt_reg <= low_cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst || state_reg != pdws_q_low ||
        low_cnt_reg != CW'(HOLD_CYC) ||
        rep_cnt_reg == CW'(REPEAT_CYC - 1)) begin
      rep_cnt_reg <= '0;
    end else begin
      rep_cnt_reg <= rep_cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst || state_reg != pdws_q_idle) begin
      idle_cnt_reg <= '0;
    end else if (idle_cnt_reg != CW'(IDLE_CYC)) begin
      idle_cnt_reg <= idle_cnt_reg + CW'(1);
    end
  end

  // ------------------------------------------------------------
  // Events
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      evt <= '0;
    end else begin
      evt.step <= (state_reg == pdws_q_low &&
                   low_cnt_reg == CW'(MIN_CYC)) ||      // RQ11 RQ12
                  (state_reg == pdws_q_low &&
                   low_cnt_reg == CW'(HOLD_CYC) &&
                   rep_cnt_reg == CW'(REPEAT_CYC - 1)); // RQ14
      evt.idle <= state_reg == pdws_q_idle &&
                  idle_cnt_reg == CW'(IDLE_CYC - 1);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_fall;
    state_reg == pdws_q_idle && low;
  endsequence

  a_fall_starts_pulse: assert property ( // RQ10
    s_fall |=> state_reg == pdws_q_low ##[1:2] low_cnt_reg != '0)
    else $error("falling edge did not start a pulse");

  a_gap_merges_pulse: assert property ( // RQ13
    state_reg == pdws_q_gap && low && low_cnt_reg != '0 |=>
      state_reg == pdws_q_low && low_cnt_reg != '0)
    else $error("short gap restarted the pulse");

  a_step_needs_width: assert property ( // RQ11
    evt.step |-> $past(low_cnt_reg) >= CW'(MIN_CYC))
    else $error("step from a pulse below minimum width");
endmodule
`default_nettype wire

//--- rtl/pdws_top.sv
// Wiper position and direction control for a 64 tap rheostat
//
// Functional notes
// (RQ1) Wiper holds one of 64 tap positions
// (RQ2) Single mode: down tied high, step floating
// (RQ3) Dual mode: all control inputs open
// (RQ4) Down-tied variant always runs single mode
// (RQ5) Single mode: up contact follows direction
// (RQ6) Dual mode: up raises, down lowers
// (RQ7) Step input acts like single mode always
// (RQ8) Step input pulled up, floating is inactive
// (RQ9) Each single pulse moves one tap
// (RQ10) High inactive; falling edge starts activity
// (RQ11) Contact single pulse: over 1 ms
// (RQ12) Step input single pulse: over 1 us
// (RQ13) Under 1 ms high gap merges pulses
// (RQ14) Held over 1 s: step every 100 ms
// (RQ15) Single control reverses direction at ends
// (RQ16) One second idle reverses direction
// (RQ17) Dual mode stops at ends, no wait
// (RQ18) Store first change after 2 s, then >12.5%
// (RQ19) Inputs synchronised and timed internally
// (RQ20) Mode latched once after power-up
`include "pdws_cfg.svh"
`default_nettype none
module pdws_top #(
  parameter bit DOWN_TIED  = 1'b0,
  parameter int DIG_MIN    = `PDWS_CYC_NS(`PDWS_DIG_MIN_NS),
  parameter int CON_MIN    = `PDWS_CYC_US(`PDWS_CON_MIN_US),
  parameter int GAP_CYC    = `PDWS_CYC_US(`PDWS_GAP_US),
  parameter int HOLD_CYC   = `PDWS_CYC_MS(`PDWS_HOLD_MS),
  parameter int REPEAT_CYC = `PDWS_CYC_MS(`PDWS_REPEAT_MS),
  parameter int IDLE_CYC   = `PDWS_CYC_MS(`PDWS_IDLE_MS),
  parameter int STORE_CYC  = `PDWS_CYC_MS(`PDWS_STORE_MS)
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               up_contact_in,
  input  wire logic               down_contact_in,
  input  wire logic               digital_step_in,
  input  wire logic               down_tied_sense_in,
  input  wire pdws_pkg::pdws_pos_t nv_restore_pos,
  output var  pdws_pkg::pdws_pos_t wiper_pos,
  output var  logic               dir_up,
  output var  logic               dual_mode,
  output var  logic               init_done,
  output var  pdws_pkg::pdws_nv_s nv_out
);
  import pdws_pkg::*;

  localparam int SW = $clog2(STORE_CYC + 1);

  if (STORE_CYC < 1) begin : g_bad_store
    $error("pdws_top: store delay must be at least one cycle");
  end

  logic [2:0]  pins_n;
  pdws_evt_s   evt [3];
  logic        up_step;
  logic        down_step;
  logic        d_step;
  logic        single_step;
  logic        rev_idle;
  pdws_pos_t   pos_next;
  logic        dir_next;
  logic        moved_single_reg;
  logic        last_src_d_reg;
  logic        armed_reg;
  logic        first_pending_reg;
  logic [SW-1:0] store_cnt_reg;
  pdws_pos_t   last_stored_reg;
  pdws_pos_t   delta;

  // ------------------------------------------------------------
  // Input qualifiers: 0 up contact, 1 down contact, 2 step input
  // ------------------------------------------------------------
  assign pins_n = {digital_step_in, down_contact_in, up_contact_in};

  for (genvar i = 0; i < 3; i++) begin : g_qual
    pdws_pulse_qual #(
      .MIN_CYC   ((i == 2) ? DIG_MIN : CON_MIN),
      .GAP_CYC   (GAP_CYC),
      .HOLD_CYC  (HOLD_CYC),
      .REPEAT_CYC(REPEAT_CYC),
      .IDLE_CYC  (IDLE_CYC)
    ) u_qual (
      .clock(clock),
      .rst  (rst),
      .pin_n(pins_n[i]),
      .evt  (evt[i])
    );
  end

  assign up_step     = evt[0].step;
  assign down_step   = evt[1].step;
  assign d_step      = evt[2].step;
  // Down contact is ignored outside dual mode
  assign single_step = d_step | (up_step & !dual_mode); // RQ5 RQ7
  assign rev_idle    = moved_single_reg &
                       (last_src_d_reg ? evt[2].idle : evt[0].idle); // RQ16

  // ------------------------------------------------------------
  // Power-up capture
  // ------------------------------------------------------------
  // Straps sampled by the first clock after release, never by reset
  always_ff @(posedge clock) begin
    if (rst) begin
      init_done <= 1'b0;
      dual_mode <= 1'b0;
    end else if (!init_done) begin
      init_done <= 1'b1;
      dual_mode <= !(DOWN_TIED || down_tied_sense_in); // RQ2 RQ3 RQ4 RQ20
    end
  end

  // ------------------------------------------------------------
  // Wiper move
  // ------------------------------------------------------------
  always_comb begin
    pos_next = wiper_pos;
    dir_next = dir_up;
    if (!init_done) begin
      pos_next = nv_restore_pos;
      dir_next = 1'b1;
    end else if (single_step) begin
      if (dir_up) begin
        if (wiper_pos == `PDWS_POS_MAX) begin
          pos_next = wiper_pos - 6'h01; // RQ15
          dir_next = 1'b0;
        end else begin
          pos_next = wiper_pos + 6'h01; // RQ9
          dir_next = (wiper_pos + 6'h01) != `PDWS_POS_MAX; // RQ15
        end
      end else begin
        if (wiper_pos == `PDWS_POS_RST) begin
          pos_next = wiper_pos + 6'h01; // RQ15
          dir_next = 1'b1;
        end else begin
          pos_next = wiper_pos - 6'h01; // RQ9
          dir_next = (wiper_pos - 6'h01) == `PDWS_POS_RST; // RQ15
        end
      end
    end else if (dual_mode && up_step) begin
      // Clamp at the end; direction set at once
      if (wiper_pos != `PDWS_POS_MAX) pos_next = wiper_pos + 6'h01; // RQ6
      dir_next = 1'b1; // RQ17
    end else if (dual_mode && down_step) begin
      if (wiper_pos != `PDWS_POS_RST) pos_next = wiper_pos - 6'h01; // RQ6
      dir_next = 1'b0; // RQ17
    end else if (rev_idle) begin
      dir_next = !dir_up; // RQ16
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wiper_pos <= `PDWS_POS_RST;
      dir_up    <= 1'b1;
    end else begin
      wiper_pos <= pos_next; // RQ1
      dir_up    <= dir_next;
    end
  end

  // Which single-style input moved last, for idle reversal
  always_ff @(posedge clock) begin
    if (rst) begin
      moved_single_reg <= 1'b0;
      last_src_d_reg   <= 1'b0;
    end else if (single_step) begin
      moved_single_reg <= 1'b1;
      last_src_d_reg   <= d_step;
    end else if (rev_idle || (dual_mode && (up_step || down_step))) begin
      moved_single_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Nonvolatile store scheduling
  // ------------------------------------------------------------
  // Small moves are skipped to spare memory wear
  assign delta = (wiper_pos > last_stored_reg) ?
                 wiper_pos - last_stored_reg :
                 last_stored_reg - wiper_pos;

  always_ff @(posedge clock) begin
    if (rst) begin
      armed_reg         <= 1'b0;
      first_pending_reg <= 1'b1;
      store_cnt_reg     <= '0;
      last_stored_reg   <= `PDWS_POS_RST;
      nv_out            <= '0;
    end else begin
      nv_out.strobe <= 1'b0;
      if (!init_done) begin
        last_stored_reg <= nv_restore_pos;
      end else if (pos_next != wiper_pos) begin
        armed_reg     <= 1'b1;
        store_cnt_reg <= '0;
      end else if (armed_reg) begin
        store_cnt_reg <= store_cnt_reg + SW'(1);
        if (store_cnt_reg == SW'(STORE_CYC - 1)) begin
          armed_reg <= 1'b0;
          if (first_pending_reg || delta > `PDWS_STORE_MIN_DELTA) begin
            nv_out.strobe     <= 1'b1; // RQ18
            nv_out.data       <= wiper_pos;
            last_stored_reg   <= wiper_pos;
            first_pending_reg <= 1'b0;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_wiper_unit_step: assert property ( // RQ9
    init_done && $past(init_done) && $changed(wiper_pos) |->
      wiper_pos == $past(wiper_pos) + 6'h01 ||
      wiper_pos == $past(wiper_pos) - 6'h01)
    else $error("wiper moved by more than one tap");

  a_mode_frozen: assert property ( // RQ20
    init_done && $past(init_done) |-> $stable(dual_mode))
    else $error("mode changed after power-up");

  a_tied_single: assert property ( // RQ4
    DOWN_TIED && init_done |-> !dual_mode)
    else $error("down-tied variant left single mode");

  a_dual_clamp_top: assert property ( // RQ17
    init_done && dual_mode && up_step && !single_step &&
    wiper_pos == `PDWS_POS_MAX |=> wiper_pos == `PDWS_POS_MAX && dir_up)
    else $error("dual mode did not hold at top end");

  sequence s_single_hits_top;
    init_done && single_step && dir_up && wiper_pos == 6'h3E;
  endsequence

  a_single_bounce_end: assert property ( // RQ15
    s_single_hits_top |=> wiper_pos == `PDWS_POS_MAX && !dir_up)
    else $error("direction did not reverse at end");

  a_dual_up_only: assert property ( // RQ6
    init_done && dual_mode && up_step && !d_step &&
    wiper_pos != `PDWS_POS_MAX |=> wiper_pos == $past(wiper_pos) + 6'h01)
    else $error("up contact did not raise wiper");

  a_idle_reverses: assert property ( // RQ16
    init_done && rev_idle && !single_step && !up_step && !down_step |=>
      dir_up != $past(dir_up))
    else $error("idle did not reverse direction");

  a_store_after_delay: assert property ( // RQ18
    nv_out.strobe |-> $past(armed_reg) &&
      $past(store_cnt_reg) == SW'(STORE_CYC - 1) &&
      nv_out.data == wiper_pos)
    else $error("store issued without full delay");
endmodule
`default_nettype wire

//--- test/pdws_pulse_src.sv
// Pulse source standing in for pushbuttons and a microcontroller
`default_nettype none
module pdws_pulse_src (
  input  wire logic clock,
  output var  logic up_contact_in,
  output var  logic down_contact_in,
  output var  logic digital_step_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Released lines sit at the pull-up level
  // ----------------------------------------
  initial begin
    up_contact_in   = 1'b1;
    down_contact_in = 1'b1;
    digital_step_in = 1'b1;
  end

  // Caller picks the high time; short ones merge on purpose
  task automatic drive(input int sel, input int low_cyc, input int high_cyc);
    @(negedge clock);
    case (sel)
      0: up_contact_in = 1'b0;
      1: down_contact_in = 1'b0;
      default: digital_step_in = 1'b0;
    endcase
    repeat (low_cyc) @(negedge clock);
    up_contact_in   = 1'b1;
    down_contact_in = 1'b1;
    digital_step_in = 1'b1;
    repeat (high_cyc) @(negedge clock);
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking testbench for the wiper stepper
`default_nettype none
module tb;
  import pdws_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Shortened timing, in cycles
  // ----------------------------------------
  localparam int P_DIG   = 2;
  localparam int P_CON   = 4;
  localparam int P_GAP   = 4;
  localparam int P_HOLD  = 40;
  localparam int P_REP   = 8;
  localparam int P_IDLE  = 30;
  localparam int P_STORE = 20;

  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       up_contact_in;
  logic       down_contact_in;
  logic       digital_step_in;
  logic       down_tied_sense_in = 1'b1;
  pdws_pos_t  nv_restore_pos = 6'h00;
  pdws_pos_t  wiper_pos;
  logic       dir_up;
  logic       dual_mode;
  logic       init_done;
  pdws_nv_s   nv_out;
  logic       tied_dual;
  logic [5:0] strobe_cnt;
  pdws_pos_t  last_nv;
  pdws_pos_t  exp_pos;
  logic       exp_dir;
  int         failures = 0;
  int         check_count = 0;
  int         sel;

  always #10 clock = ~clock;

  pdws_pulse_src src (
    .clock           (clock),
    .up_contact_in   (up_contact_in),
    .down_contact_in (down_contact_in),
    .digital_step_in (digital_step_in)
  );

  pdws_top #(.DIG_MIN(P_DIG), .CON_MIN(P_CON), .GAP_CYC(P_GAP),
    .HOLD_CYC(P_HOLD), .REPEAT_CYC(P_REP), .IDLE_CYC(P_IDLE),
    .STORE_CYC(P_STORE)) uut (
    .clock(clock), .rst(rst), .up_contact_in(up_contact_in),
    .down_contact_in(down_contact_in), .digital_step_in(digital_step_in),
    .down_tied_sense_in(down_tied_sense_in), .nv_restore_pos(nv_restore_pos),
    .wiper_pos(wiper_pos), .dir_up(dir_up), .dual_mode(dual_mode),
    .init_done(init_done), .nv_out(nv_out)
  );

  // Variant with the down contact strapped high inside
  pdws_top #(.DOWN_TIED(1'b1)) uut_tied (
    .clock(clock), .rst(rst), .up_contact_in(up_contact_in),
    .down_contact_in(down_contact_in), .digital_step_in(digital_step_in),
    .down_tied_sense_in(down_tied_sense_in), .nv_restore_pos(nv_restore_pos),
    .wiper_pos(), .dir_up(), .dual_mode(tied_dual), .init_done(),
    .nv_out()
  );

  always @(posedge clock) begin
    if (rst) begin
      strobe_cnt <= 6'h00;
    end else if (nv_out.strobe === 1'b1) begin
      strobe_cnt <= strobe_cnt + 6'h01;
      last_nv <= nv_out.data;
    end
  end

  // ----------------------------------------
  // Compare and model tasks
  // ----------------------------------------
  task automatic chk_val(input string nm, input logic [5:0] e,
                         input logic [5:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Kind 1 single style, 2 dual up, 3 dual down, 0 no move
  task automatic model(input int kind);
    case (kind)
      1: begin
        if (exp_dir && exp_pos == 6'h3F) exp_dir = 1'b0;
        else if (!exp_dir && exp_pos == 6'h00) exp_dir = 1'b1;
        exp_pos = exp_dir ? exp_pos + 6'h01 : exp_pos - 6'h01;
        if (exp_pos == 6'h3F) exp_dir = 1'b0;
        if (exp_pos == 6'h00) exp_dir = 1'b1;
      end
      2: begin
        exp_dir = 1'b1;
        if (exp_pos != 6'h3F) exp_pos = exp_pos + 6'h01;
      end
      3: begin
        exp_dir = 1'b0;
        if (exp_pos != 6'h00) exp_pos = exp_pos - 6'h01;
      end
      default: ;
    endcase
  endtask

  task automatic act(input int s, input int low, input int gap,
                     input int nst, input int kind);
    src.drive(s, low, gap);
    repeat (nst) model(kind);
    chk_val("wiper_pos", exp_pos, wiper_pos);
    chk_bit("dir_up", exp_dir, dir_up);
  endtask

  // Only used right after a single style step
  task automatic idle_flip();
    repeat (60) @(negedge clock);
    exp_dir = ~exp_dir;
    chk_bit("dir_up_idle", exp_dir, dir_up);
  endtask

  task automatic do_reset(input logic sense, input pdws_pos_t restore);
    @(negedge clock);
    rst = 1'b1;
    down_tied_sense_in = sense;
    nv_restore_pos = restore;
    repeat (2) @(negedge clock);
    chk_val("reset_pos", 6'h00, wiper_pos);
    chk_bit("init_done", 1'b0, init_done);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    exp_pos = restore;
    exp_dir = 1'b1;
    chk_val("restore_pos", exp_pos, wiper_pos);
    chk_bit("init_done", 1'b1, init_done);
    chk_bit("dual_mode", ~sense, dual_mode);
    chk_bit("tied_dual", 1'b0, tied_dual);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(62));
    do_reset(1'b1, 6'($urandom_range(50, 10)));
    for (int i = 0; i < 6; i++) begin
      sel = ($urandom_range(1, 0) == 0) ? 0 : 2;
      act(sel, $urandom_range(30, (sel == 2) ? 3 : 5),
          $urandom_range(14, 8), 1, 1);
    end
    // Idle reversal, then three pulses that give no step, one that steps and a merged pair with one step
    idle_flip();
    act(1, 7, 8, 1, 0);
    act(2, P_DIG - 1, 8, 1, 0);
    act(0, P_CON - 1, 8, 1, 0);
    act(0, P_CON + 1, 8, 1, 1);
    src.drive(2, 4, 2);
    act(2, 4, 8, 1, 1);
    // End reversal under a held pulse, then storage thresholds
    do_reset(1'b1, 6'h3E);
    // Length kept clear of the next repeat edge
    act(2, P_HOLD + 2 * P_REP + 4, 8, 3, 1);
    idle_flip();
    chk_val("store_count", 6'h01, strobe_cnt);
    // First change is stored during the hold, however small
    chk_val("store_data", 6'h3F, last_nv);
    act(2, 4, 8, 1, 1);
    idle_flip();
    chk_val("store_count", 6'h01, strobe_cnt);
    act(2, P_HOLD + 9 * P_REP + 4, 8, 10, 1);
    idle_flip();
    chk_val("store_count", 6'h02, strobe_cnt);
    chk_val("store_data", 6'h34, last_nv);
    // Dual mode, latched against a later strap change
    do_reset(1'b0, 6'h3D);
    @(negedge clock);
    down_tied_sense_in = 1'b1;
    repeat (2) @(negedge clock);
    chk_bit("dual_latched", 1'b1, dual_mode);
    act(0, 7, 8, 1, 2);
    act(0, 7, 8, 1, 2);
    act(0, 7, 8, 1, 2);
    act(1, 7, 8, 1, 3);
    act(1, 7, 8, 1, 3);
    act(2, 4, 8, 1, 1);
    finish_test();
  end
endmodule
`default_nettype wire
